// ===== logic/lsc_pkg.sv
// shared constants and types of the serial led sink control block
package lsc_pkg;
   localparam int unsigned LSC_CH       = 8;
   localparam int unsigned LSC_AW       = 8;
   localparam int unsigned LSC_EV       = 5;
   // register byte offsets on the apb slave
   localparam logic [7:0]  LSC_OFF_CTRL = 8'h00;
   localparam logic [7:0]  LSC_OFF_STAT = 8'h04;
   localparam logic [7:0]  LSC_OFF_IST  = 8'h08;
   localparam logic [7:0]  LSC_OFF_ICLR = 8'h0c;
   localparam logic [7:0]  LSC_OFF_IEN  = 8'h10;
   // event bit positions in the interrupt registers
   localparam int unsigned LSC_EV_NORM  = 0;
   localparam int unsigned LSC_EV_SPEC  = 1;
   localparam int unsigned LSC_EV_LATCH = 2;
   localparam int unsigned LSC_EV_CFG   = 3;
   localparam int unsigned LSC_EV_ERR   = 4;
   // values after reset
   localparam logic [7:0]  LSC_RST_LATCH = 8'h00;
   localparam logic [7:0]  LSC_RST_CFG   = 8'hff;
   localparam logic [7:0]  LSC_RST_ERR   = 8'h00;
   localparam logic [4:0]  LSC_RST_IEN   = 5'h00;
   localparam logic        LSC_RST_OE_N  = 1'b1;
   // cycles from apb access phase to pready
   localparam int unsigned LSC_APB_WAIT  = 1;

   typedef enum logic [1:0] {
      LSC_NORMAL,
      LSC_SWITCH,
      LSC_SPECIAL
   } lsc_mode_e;
endpackage : lsc_pkg

// ===== logic/lsc_sh_if.sv
// interface between the controller and the eight-stage shift register
`timescale 1ns/100ps
`default_nettype none
interface lsc_sh_if #(parameter int unsigned W = lsc_pkg::LSC_CH);
   logic         shift_en;
   logic         load_en;
   logic         serial_in;
   logic [W-1:0] load_data;
   logic [W-1:0] q;
   modport ctrl (output shift_en, output load_en, output serial_in, output load_data, input q);
   modport sreg (input shift_en, input load_en, input serial_in, input load_data, output q);
endinterface : lsc_sh_if
`default_nettype wire

// ===== logic/lsc_sync.sv
// two-stage synchroniser for pins from outside the mclk domain
`timescale 1ns/100ps
`default_nettype none
module lsc_sync #(
   parameter int unsigned    W   = 4,
   parameter logic [W-1:0]   RST = '0
) (
   input  wire logic         mclk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_s
);
   logic [W-1:0] meta_q;

   // meta_q feeds pin_s only
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= RST;
         pin_s  <= RST;
      end else begin
         meta_q <= pin_in;
         pin_s  <= meta_q;
      end
   end
endmodule : lsc_sync
`default_nettype wire

// ===== logic/lsc_shreg.sv
// eight-stage shift register with parallel load of error status
`timescale 1ns/100ps
`default_nettype none
module lsc_shreg #(
   parameter int unsigned W = lsc_pkg::LSC_CH
) (
   input  wire logic mclk,
   input  wire logic resetn,
   lsc_sh_if.sreg    sh
);
   logic [W-1:0] q_q;

   assign sh.q = q_q;

   // parallel load wins; the bit arriving on a load edge is dropped
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         q_q <= '0;
      end else if (sh.load_en) begin
         q_q <= sh.load_data;
      end else if (sh.shift_en) begin
         q_q <= {q_q[W-2:0], sh.serial_in};
      end
   end

   a_shift_advance: assert property (@(posedge mclk) disable iff (!resetn)
      (sh.shift_en && !sh.load_en) |=> q_q == {$past(q_q[W-2:0]), $past(sh.serial_in)})
      else $error("shift register did not advance by one");
   a_status_load: assert property (@(posedge mclk) disable iff (!resetn)
      sh.load_en |=> q_q == $past(sh.load_data))
      else $error("error status not loaded into shift register");
endmodule : lsc_shreg
`default_nettype wire

// ===== logic/lsc_led_sink_ctrl.sv
// control logic of the eight-channel led sink driver with apb status port
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - eight-stage shift register feeding parallel latches
// - shift one place per serial clock rise
// - normal mode: shift serial_in, oldest bit out
// - latch transparent while strobe high, holds after
// - enable low follows latch unless ctrl blank bit set, high blanks all
// - one-clock enable pulse enters mode switching
// - strobe level during switching picks the mode
// - normal, special and switching phase only
// - normal strobe copies shift register to outputs
// - special mode enable low drives and checks
// - special mode loads error status, shifts out
// - special strobe writes config latch, outputs kept
// - config code is 256-step global gain
// - config code always drives current regulator
// - serial_out drives next driver or controller
// - return to normal clears error bits
// - one shared error bit per channel
module lsc_led_sink_ctrl (
   input  wire logic                       mclk,
   input  wire logic                       resetn,
   // apb slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [lsc_pkg::LSC_AW-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   output logic                            irq,
   // serial link pins
   input  wire logic                       serial_clk,
   input  wire logic                       serial_in,
   input  wire logic                       latch_strobe_mode_sel,
   input  wire logic                       output_enable_n_mode_pulse,
   output logic                            serial_out,
   // channel side
   input  wire logic [lsc_pkg::LSC_CH-1:0] channel_fault,
   output logic      [lsc_pkg::LSC_CH-1:0] channel_sinks,
   output logic      [7:0]                 gain_code
);
   localparam int unsigned CH  = lsc_pkg::LSC_CH;
   localparam int unsigned EV  = lsc_pkg::LSC_EV;
   localparam int unsigned SW  = CH + 4;
   localparam logic [SW-1:0] SRST = {{CH{1'b0}}, 3'h0, lsc_pkg::LSC_RST_OE_N};

   lsc_sh_if #(.W(CH)) sh ();

   // pins synchronised; enable pulls up to blanked, strobe pulls down
   logic [SW-1:0]   pins_s;
   logic [CH-1:0]   fault_s;
   logic            sclk_s;
   logic            sin_s;
   logic            le_s;
   logic            oe_s;
   logic            sclk_prev_q;
   logic            le_prev_q;
   logic            oe_e1_q;
   logic            oe_e2_q;

   lsc_sync #(
      .W   (SW),
      .RST (SRST)
   ) u_sync (
      .mclk   (mclk),
      .resetn (resetn),
      .pin_in ({channel_fault, serial_clk, serial_in, latch_strobe_mode_sel,
                output_enable_n_mode_pulse}),
      .pin_s  (pins_s)
   );

   assign fault_s = pins_s[SW-1:4];
   assign sclk_s  = pins_s[3];
   assign sin_s   = pins_s[2];
   assign le_s    = pins_s[1];
   assign oe_s    = pins_s[0];

   // serial clock edge found by sampling; link must run well below mclk/4
   wire sclk_rise = sclk_s & ~sclk_prev_q;
   wire le_fall   = le_prev_q & ~le_s;
   // enable high at exactly one serial edge between two low ones
   wire mode_pulse = sclk_rise & ~oe_s & oe_e1_q & ~oe_e2_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sclk_prev_q <= 1'b0;
         le_prev_q   <= 1'b0;
         oe_e1_q     <= lsc_pkg::LSC_RST_OE_N;
         oe_e2_q     <= lsc_pkg::LSC_RST_OE_N;
      end else begin
         sclk_prev_q <= sclk_s;
         le_prev_q   <= le_s;
         oe_e1_q     <= sclk_rise ? oe_s : oe_e1_q;
         oe_e2_q     <= sclk_rise ? oe_e1_q : oe_e2_q;
      end
   end

   // mode state machine
   lsc_pkg::lsc_mode_e mode_q;
   lsc_pkg::lsc_mode_e mode_d;

   always_comb begin
      mode_d = mode_q;
      unique case (mode_q)
         lsc_pkg::LSC_NORMAL,
         lsc_pkg::LSC_SPECIAL: begin
            if (mode_pulse) begin
               mode_d = lsc_pkg::LSC_SWITCH;
            end
         end
         lsc_pkg::LSC_SWITCH: begin
            if (sclk_rise) begin
               mode_d = le_s ? lsc_pkg::LSC_SPECIAL : lsc_pkg::LSC_NORMAL;
            end
         end
         default: mode_d = lsc_pkg::LSC_NORMAL;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= lsc_pkg::LSC_NORMAL;
      end else begin
         mode_q <= mode_d;
      end
   end

   wire in_normal    = (mode_q == lsc_pkg::LSC_NORMAL);
   wire in_special   = (mode_q == lsc_pkg::LSC_SPECIAL);
   wire in_switch    = (mode_q == lsc_pkg::LSC_SWITCH);
   wire enter_normal = in_switch & sclk_rise & ~le_s;
   wire enter_spec   = in_switch & sclk_rise & le_s;

   // shared error register, one bit per channel
   logic [CH-1:0] err_q;
   wire           err_check = in_special & sclk_rise & ~oe_s;
   wire           err_new   = err_check & |(fault_s & ~err_q);
   wire  [CH-1:0] err_d     = enter_normal ? lsc_pkg::LSC_RST_ERR :
                              err_check    ? (err_q | fault_s) : err_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         err_q <= lsc_pkg::LSC_RST_ERR;
      end else begin
         err_q <= err_d;
      end
   end

   // status loads when enable rises in special mode, then shifts out
   assign sh.shift_en  = sclk_rise;
   assign sh.serial_in = sin_s;
   assign sh.load_en   = sclk_rise & in_special & oe_s & ~oe_e1_q;
   assign sh.load_data = err_q;

   lsc_shreg #(.W(CH)) u_shreg (
      .mclk   (mclk),
      .resetn (resetn),
      .sh     (sh.sreg)
   );

   // oldest stage drives the pin directly from a flop
   assign serial_out = sh.q[CH-1];

   // mode-select level still high after entry is no config write; wait for its fall
   logic          sel_hold_q;
   wire           sel_hold_d = enter_spec | (sel_hold_q & le_s);
   wire           cfg_wr     = in_special & le_s & ~sel_hold_q;

   // output latch is transparent while strobe is high in normal mode, configuration latch in special mode
   logic [CH-1:0] latch_q;
   logic [CH-1:0] sinks_q;
   logic [7:0]    cfg_q;
   logic          blank_q;
   wire  [CH-1:0] latch_d = (in_normal & le_s) ? sh.q : latch_q;
   wire  [7:0]    cfg_d   = cfg_wr ? sh.q : cfg_q;
   wire  [CH-1:0] sinks_d = (oe_s | blank_q) ? '0 : latch_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         latch_q    <= lsc_pkg::LSC_RST_LATCH;
         cfg_q      <= lsc_pkg::LSC_RST_CFG;
         sinks_q    <= '0;
         sel_hold_q <= 1'b0;
      end else begin
         latch_q    <= latch_d;
         cfg_q      <= cfg_d;
         sinks_q    <= sinks_d;
         sel_hold_q <= sel_hold_d;
      end
   end

   assign channel_sinks = sinks_q;
   // code 0..255 maps linearly onto the regulator gain range
   assign gain_code     = cfg_q;

   // apb slave: one wait state, pready and prdata from flops
   logic          pready_q;
   logic          pslverr_q;
   logic [31:0]   prdata_q;
   logic [EV-1:0] ist_q;
   logic [EV-1:0] ien_q;
   logic          irq_q;

   wire apb_acc  = psel & penable & ~pready_q;
   wire apb_done = psel & penable & pready_q;
   wire apb_wr   = apb_done & pwrite;
   wire sel_ctrl = (paddr == lsc_pkg::LSC_OFF_CTRL);
   wire sel_stat = (paddr == lsc_pkg::LSC_OFF_STAT);
   wire sel_ist  = (paddr == lsc_pkg::LSC_OFF_IST);
   wire sel_iclr = (paddr == lsc_pkg::LSC_OFF_ICLR);
   wire sel_ien  = (paddr == lsc_pkg::LSC_OFF_IEN);
   wire mapped   = sel_ctrl | sel_stat | sel_ist | sel_iclr | sel_ien;

   wire [31:0] rd_mux = sel_ctrl ? {31'h0, blank_q} :
                        sel_stat ? {err_q, cfg_q, latch_q, 6'h00, mode_q} :
                        sel_ist  ? {27'h0, ist_q} :
                        sel_ien  ? {27'h0, ien_q} : 32'h0;

   // events; a set in the clearing cycle wins
   logic [EV-1:0] ev;
   always_comb begin
      ev = '0;
      ev[lsc_pkg::LSC_EV_NORM]  = enter_normal;
      ev[lsc_pkg::LSC_EV_SPEC]  = enter_spec;
      ev[lsc_pkg::LSC_EV_LATCH] = in_normal & le_fall;
      ev[lsc_pkg::LSC_EV_CFG]   = in_special & le_fall & ~sel_hold_q;
      ev[lsc_pkg::LSC_EV_ERR]   = err_new;
   end

   wire [EV-1:0] clr   = (apb_wr & sel_iclr) ? pwdata[EV-1:0] : '0;
   wire [EV-1:0] ist_d = (ist_q & ~clr) | ev;
   wire [EV-1:0] ien_d = (apb_wr & sel_ien) ? pwdata[EV-1:0] : ien_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
         blank_q   <= 1'b0;
         ist_q     <= '0;
         ien_q     <= lsc_pkg::LSC_RST_IEN;
         irq_q     <= 1'b0;
      end else begin
         pready_q  <= apb_acc;
         pslverr_q <= apb_acc & ~mapped;
         prdata_q  <= apb_acc ? rd_mux : 32'h0;
         blank_q   <= (apb_wr & sel_ctrl) ? pwdata[0] : blank_q;
         ist_q     <= ist_d;
         ien_q     <= ien_d;
         irq_q     <= |(ist_d & ien_d);
      end
   end

   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign prdata  = prdata_q;
   assign irq     = irq_q;

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence s_pulse_seen;
      mode_pulse && !in_switch;
   endsequence
   sequence s_back_to_normal;
      in_switch && sclk_rise && !le_s;
   endsequence
   sequence s_special_entry;
      in_switch && sclk_rise && le_s;
   endsequence
   sequence s_status_rise;
      in_special && sclk_rise && oe_s && !oe_e1_q;
   endsequence
   sequence s_apb_answer;
      psel && penable && pready;
   endsequence

   a_latch_follow: assert property (in_normal && le_s |=> latch_q == $past(sh.q))
      else $error("output latch not transparent while strobe high");
   a_latch_hold: assert property (!le_s |=> latch_q == $past(latch_q))
      else $error("output latch changed with strobe low");
   a_blank_all: assert property (oe_s |=> channel_sinks == '0)
      else $error("channels on while enable high");
   a_enable_follow: assert property (!oe_s && !blank_q |=> channel_sinks == $past(latch_q))
      else $error("channels do not follow latch");
   a_pulse_enter: assert property (s_pulse_seen |=> in_switch)
      else $error("mode pulse did not enter switching");
   a_mode_select: assert property (in_switch && sclk_rise |=>
      mode_q == ($past(le_s) ? lsc_pkg::LSC_SPECIAL : lsc_pkg::LSC_NORMAL))
      else $error("wrong mode chosen from strobe level");
   a_special_keeps: assert property (in_special |=> latch_q == $past(latch_q))
      else $error("output latch changed in special mode");
   a_cfg_write: assert property (cfg_wr |=> gain_code == $past(sh.q))
      else $error("config latch not written in special mode");
   a_errors_clear: assert property (s_back_to_normal |=> err_q == '0 ##1 in_normal)
      else $error("error bits not cleared on return to normal");
   a_irq_level: assert property (irq == |(ist_q & ien_q))
      else $error("interrupt does not match enabled status");
   a_entry_guard: assert property (s_special_entry |=> in_special && sel_hold_q)
      else $error("mode-select strobe not guarded on entry");
   a_cfg_kept: assert property (in_special && sel_hold_q |=>
      gain_code == $past(gain_code))
      else $error("config changed by mode-select strobe");
   a_gain_steady: assert property (!cfg_wr |=> gain_code == $past(gain_code))
      else $error("gain code changed without a config write");
   a_status_shift: assert property (s_status_rise |=> sh.q == $past(err_q))
      else $error("error status not placed in shift register");
   a_load_special: assert property (sh.load_en |-> in_special)
      else $error("status load outside special mode");
   a_mode_persist: assert property (!in_switch && !mode_pulse |=>
      mode_q == $past(mode_q))
      else $error("mode changed without a mode pulse");
   a_switch_waits: assert property (in_switch && !sclk_rise |=> in_switch)
      else $error("left switching without a serial edge");
   a_err_sticky: assert property (in_special && !err_check |=> err_q == $past(err_q))
      else $error("error bits changed outside a check");
   a_err_collect: assert property (err_check |=>
      (err_q & $past(fault_s)) == $past(fault_s))
      else $error("detected fault not recorded");
   a_err_normal: assert property (in_normal |-> err_q == '0)
      else $error("error bits set in normal mode");
   a_sout_steady: assert property (!sclk_rise |=> serial_out == $past(serial_out))
      else $error("serial output moved without a serial edge");
   a_blank_reg: assert property (blank_q |=> channel_sinks == '0)
      else $error("channels on while blanked by register");

   // bus answer: one-cycle pulse, data only with it
   a_apb_pulse: assert property (s_apb_answer |=> !pready)
      else $error("pready longer than one cycle");
   a_rdata_quiet: assert property (!pready |-> prdata == '0)
      else $error("read data outside the answer cycle");
   a_slverr_pair: assert property (pslverr |-> pready)
      else $error("error response without pready");
endmodule : lsc_led_sink_ctrl
`default_nettype wire

// ===== test/lsc_ctl_model.sv
// controller-side model that drives the serial link pins
`timescale 1ns/100ps
`default_nettype none
module lsc_ctl_model (
   output var logic serial_clk,
   output var logic serial_in,
   output var logic latch_strobe_mode_sel,
   output var logic output_enable_n_mode_pulse,
   input  wire logic serial_out
);
   localparam realtime HALF = 62.5;
   initial begin
      serial_clk = 1'b0;
      serial_in = 1'b0;
      latch_strobe_mode_sel = 1'b0;
      output_enable_n_mode_pulse = 1'b1;
   end
   // one serial clock period; clock stands low between frames
   task rise(input logic oe, input logic d, output logic s);
      output_enable_n_mode_pulse = oe;
      serial_in = d;
      #HALF s = serial_out;
      serial_clk = 1'b1;
      #HALF serial_clk = 1'b0;
   endtask : rise
   // msb first, serial_out sampled just before each rise
   task shift8(input logic [7:0] b, input logic oe, output logic [7:0] s);
      for (int i = 7; i >= 0; i--) rise(oe, b[i], s[i]);
      // no pull on the data line, so never leave the last bit standing
      serial_in = ~serial_in;
   endtask : shift8
   task mode_switch(input logic sel);
      logic s;
      rise(1'b0, 1'b0, s);
      rise(1'b1, 1'b0, s);
      rise(1'b0, 1'b0, s);
      latch_strobe_mode_sel = sel;
      rise(1'b0, 1'b0, s);
      latch_strobe_mode_sel = 1'b0;
   endtask : mode_switch
   task strobe;
      latch_strobe_mode_sel = 1'b1;
      #100 latch_strobe_mode_sel = 1'b0;
      #100;
   endtask : strobe
   task enable(input logic oe);
      output_enable_n_mode_pulse = oe;
      #100;
   endtask : enable
endmodule : lsc_ctl_model
`default_nettype wire

// ===== test/lsc_led_sink_ctrl_tb_top.sv
// self-checking bench: apb register access and link pin sequences
`timescale 1ns/100ps
`default_nettype none
module lsc_led_sink_ctrl_tb_top;
   localparam logic [31:0] EVL = 32'h1 << lsc_pkg::LSC_EV_LATCH;
   logic        mclk = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        err;
   logic        b;
   wire logic   sclk;
   wire logic   sin;
   wire logic   stb;
   wire logic   oe_n;
   wire logic   sout;
   logic [7:0]  fault = 8'h00;
   logic [7:0]  sinks;
   logic [7:0]  gain;
   logic [7:0]  so;
   int          fail_count = 0;
   int          tests_run = 0;
   always #5 mclk = ~mclk;
   lsc_led_sink_ctrl dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .serial_clk(sclk), .serial_in(sin),
      .latch_strobe_mode_sel(stb), .output_enable_n_mode_pulse(oe_n), .serial_out(sout),
      .channel_fault(fault), .channel_sinks(sinks), .gain_code(gain));
   lsc_ctl_model m (.serial_clk(sclk), .serial_in(sin), .latch_strobe_mode_sel(stb),
      .output_enable_n_mode_pulse(oe_n), .serial_out(sout));
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // setup, then access held until pready is seen at a rising edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      // no wait count assumed; the watchdog ends a hang
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task print_verdict;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   initial begin
      #200us;
      fail_count++;
      print_verdict();
   end
   initial begin
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      apb(1'b0, lsc_pkg::LSC_OFF_STAT, 32'h0);
      chk("status", 32'h00ff0000, rd);
      chk("sinks", 32'h0, 32'(sinks));
      apb(1'b1, lsc_pkg::LSC_OFF_IEN, EVL);
      m.shift8(8'ha5, 1'b0, so);
      m.strobe();
      chk("sinks", 32'ha5, 32'(sinks));
      chk("irq", 32'h1, 32'(irq));
      m.shift8(8'h3c, 1'b0, so);
      chk("sout", 32'ha5, 32'(so));
      chk("held", 32'ha5, 32'(sinks));
      apb(1'b1, lsc_pkg::LSC_OFF_ICLR, EVL);
      apb(1'b0, lsc_pkg::LSC_OFF_IST, 32'h0);
      chk("iclr", 32'h0, rd & EVL);
      apb(1'b1, lsc_pkg::LSC_OFF_IEN, 32'h0);
      m.strobe();
      chk("masked", 32'h0, 32'(irq));
      apb(1'b0, lsc_pkg::LSC_OFF_IST, 32'h0);
      chk("ist", EVL, rd & EVL);
      m.enable(1'b1);
      chk("off", 32'h0, 32'(sinks));
      m.enable(1'b0);
      chk("on", 32'h3c, 32'(sinks));
      apb(1'b1, lsc_pkg::LSC_OFF_CTRL, 32'h1);
      repeat (5) @(posedge mclk);
      chk("ctrl", 32'h0, 32'(sinks));
      apb(1'b1, lsc_pkg::LSC_OFF_CTRL, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("slverr", 32'h1, 32'(err));
      chk("unmapped", 32'h0, rd);
      m.mode_switch(1'b1);
      apb(1'b0, lsc_pkg::LSC_OFF_STAT, 32'h0);
      chk("mode", 32'h2, rd & 32'h3);
      chk("cfgkeep", 32'hff, 32'(gain));
      m.shift8(8'h5a, 1'b0, so);
      m.strobe();
      chk("gain", 32'h5a, 32'(gain));
      chk("kept", 32'h3c, 32'(sinks));
      @(posedge mclk);
      fault <= 8'h81;
      m.rise(1'b0, 1'b0, b);
      @(posedge mclk);
      fault <= 8'h00;
      m.rise(1'b1, 1'b0, b);
      m.shift8(8'h00, 1'b1, so);
      chk("errout", 32'h81, 32'(so));
      apb(1'b0, lsc_pkg::LSC_OFF_STAT, 32'h0);
      chk("errreg", 32'h81, rd >> 24);
      m.mode_switch(1'b0);
      apb(1'b0, lsc_pkg::LSC_OFF_STAT, 32'h0);
      chk("normal", 32'h005a3c00, rd);
      apb(1'b0, lsc_pkg::LSC_OFF_IST, 32'h0);
      chk("events", 32'h1f, rd);
      print_verdict();
   end
endmodule : lsc_led_sink_ctrl_tb_top
`default_nettype wire
